// [rtl/sea_top.sv]
// serial eeprom autoload and single word access engine with an axi4-lite register slave
// assumes a two-wire eeprom with pull-up on the data line; eeprom clock is divided from aclk
`timescale 1ns/1ps
`default_nettype none
`include "sea_consts.svh"
// Function
// (R1) start bit 0 to 1 launches cycle; wr selects
// (R2) start bit self-clears when the cycle ends
// (R3) missing eeprom acknowledge sets error bit
// (R4) read-only bit flags successful autoload
// (R5) eeprom clock divided by selected divisor
// (R6) autoload runs unless disable bit is one
// (R7) fast bit makes autoload eight times faster
// (R8) in-progress bit high only during autoload
// (R9) word address taken from bits 15:9
// (R10) write cycle sends data bits 31:16
// (R11) read cycle returns word into data field
// (R12) software waits for idle before next change
module sea_top import sea_pkg::*; #(
  parameter int AW = 12,
  parameter logic [12:0] DIV0 = `SEA_DIV0,
  parameter logic [12:0] DIV1 = `SEA_DIV1,
  parameter logic [12:0] DIV2 = `SEA_DIV2,
  parameter logic [12:0] DIV3 = `SEA_DIV3,
  parameter int AL_WORDS = `SEA_AL_WORDS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ee_scl,
  input wire logic ee_sda_i,
  output logic ee_sda_o,
  output logic ee_sda_oe_n,
  output sea_cfg_t cfg_word,
  output logic irq
);

  initial begin
    if (AW < 8 || AL_WORDS < 1 || AL_WORDS > 128 || DIV3 < 13'h0020 ||
        DIV0[4:0] != 5'h00 || DIV1[4:0] != 5'h00 || DIV2[4:0] != 5'h00 || DIV3[4:0] != 5'h00) begin
      $error("sea_top: unsupported parameter values");
    end
  end

  sea_ctrl_t ctrl_q;
  sea_state_t st_q, st_d;
  sea_cfg_t cfg_q;
  logic [`SEA_IRQ_W-1:0] istat_q, imask_q, ev;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q, rd_mux, wmerge;
  logic [3:0] wstrb_q;
  logic [AW-1:0] awaddr_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [12:0] qcnt_q, qdiv, base;
  logic [7:0] sh_q, sh_d;
  logic [15:0] rx_q;
  logic [6:0] al_idx_q, word_addr;
  logic abort_q, al_pend_q, scl_q, sda_oe_n_q, sda_o_q;
  logic s1_q, s2_q, s3_q, sda_q;
  logic wr_fire, wr_ctrl, sw_go, al_begin, launch, tick, unit_done, is_rx, is_byte;
  logic ack_miss, fin, sw_fin, al_fin, last_word, rd_mode;

  // axi write: address and data taken independently, response after both
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  assign wr_ctrl = wr_fire && (32'({awaddr_q[AW-1:2], 2'b00}) == `SEA_OFF_CTRL);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `SEA_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        case (32'({awaddr_q[AW-1:2], 2'b00}))
          `SEA_OFF_CTRL, `SEA_OFF_ISTAT, `SEA_OFF_IMASK: bresp_q <= `SEA_RESP_OKAY;
          default: bresp_q <= `SEA_RESP_SLVERR;
        endcase
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // axi read: one outstanding, unmapped reads answer slverr with zero data
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (32'({s_axi_araddr[AW-1:2], 2'b00}))
      `SEA_OFF_CTRL: rd_mux = 32'(ctrl_q);
      `SEA_OFF_ISTAT: rd_mux = 32'(istat_q);
      `SEA_OFF_IMASK: rd_mux = 32'(imask_q);
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SEA_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      case (32'({s_axi_araddr[AW-1:2], 2'b00}))
        `SEA_OFF_CTRL, `SEA_OFF_ISTAT, `SEA_OFF_IMASK: rresp_q <= `SEA_RESP_OKAY;
        default: rresp_q <= `SEA_RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // byte-lane merge of a control write; read-only bits are masked off below
  always_comb begin
    wmerge = 32'(ctrl_q);
    for (int i = 0; i < 4; i++) begin
      if (wstrb_q[i]) begin
        wmerge[8*i +: 8] = wdata_q[8*i +: 8];
      end
    end
  end

  // start only from idle; a second 1 while running is ignored
  assign sw_go = wr_ctrl && wstrb_q[0] && wdata_q[`SEA_CTRL_START_BIT] && !ctrl_q.start &&
                 !ctrl_q.al_busy && !al_pend_q; // R1
  assign al_begin = (st_q == ST_IDLE) && al_pend_q && !ctrl_q.al_dis; // R6
  assign launch = sw_go || al_begin;

  // control/status register; hardware updates come last so they win over software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= sea_ctrl_t'(`SEA_CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= sea_ctrl_t'((32'(ctrl_q) & ~`SEA_CTRL_RW_MASK) | (wmerge & `SEA_CTRL_RW_MASK));
      end
      if (sw_go) begin
        ctrl_q.start <= 1'b1; // R1
        ctrl_q.err <= 1'b0;
      end
      if (al_begin) begin
        ctrl_q.al_busy <= 1'b1; // R8
        ctrl_q.err <= 1'b0;
      end
      if (ack_miss) begin
        ctrl_q.err <= 1'b1; // R3
      end
      if (sw_fin) begin
        ctrl_q.start <= 1'b0; // R2
        if (rd_mode && !abort_q) begin
          ctrl_q.data <= rx_q; // R11
        end
      end
      if (al_fin) begin
        ctrl_q.al_busy <= 1'b0; // R8
        ctrl_q.al_ok <= !abort_q; // R4
      end
    end
  end

  // interrupt status, write one to clear, a new event wins over the clear
  assign ev = {al_fin, ack_miss, sw_fin};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_q <= '0;
      imask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (wr_fire && 32'({awaddr_q[AW-1:2], 2'b00}) == `SEA_OFF_IMASK && wstrb_q[0]) begin
        imask_q <= wdata_q[`SEA_IRQ_W-1:0];
      end
      if (wr_fire && 32'({awaddr_q[AW-1:2], 2'b00}) == `SEA_OFF_ISTAT && wstrb_q[0]) begin
        istat_q <= (istat_q & ~wdata_q[`SEA_IRQ_W-1:0]) | ev;
      end else begin
        istat_q <= istat_q | ev;
      end
      irq_q <= |(istat_q & imask_q);
    end
  end

  // quarter-bit rate; autoload may run eight times faster
  always_comb begin
    case (ctrl_q.clk_div)
      2'b00: base = DIV0; // R5
      2'b01: base = DIV1;
      2'b10: base = DIV2;
      default: base = DIV3;
    endcase
    qdiv = base >> 2;
    if (ctrl_q.al_busy && ctrl_q.fast) begin
      qdiv = base >> (2 + `SEA_FAST_SHIFT); // R7
    end
  end

  assign tick = (st_q != ST_IDLE) && (qcnt_q == qdiv - 13'h0001);
  assign is_rx = (st_q == ST_RD_HI) || (st_q == ST_RD_LO);
  assign is_byte = !(st_q == ST_IDLE || st_q == ST_START1 || st_q == ST_RSTART || st_q == ST_STOP);
  assign unit_done = tick && (ph_q == 2'h3) && (!is_byte || bit_q == 4'h8);
  assign ack_miss = tick && (ph_q == 2'h2) && is_byte && !is_rx && bit_q == 4'h8 && sda_q; // R3
  assign fin = unit_done && (st_q == ST_STOP);
  assign last_word = 32'(al_idx_q) == AL_WORDS - 1;
  assign sw_fin = fin && !ctrl_q.al_busy; // R2
  assign al_fin = fin && ctrl_q.al_busy && (abort_q || last_word);
  assign rd_mode = ctrl_q.al_busy || !ctrl_q.wr; // R1
  // fields are sampled live, so they must stay put while a cycle runs
  assign word_addr = ctrl_q.al_busy ? al_idx_q : ctrl_q.addr; // R9 R12

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    case (st_q)
      ST_START1: begin
        st_d = ST_CTRLW;
        sh_d = {`SEA_DEV_ADDR, 1'b0};
      end
      ST_CTRLW: begin
        st_d = ST_ADDR;
        sh_d = {word_addr, 1'b0}; // R9
      end
      ST_ADDR: begin
        st_d = rd_mode ? ST_RSTART : ST_WR_HI;
        sh_d = ctrl_q.data[15:8]; // R10
      end
      ST_RSTART: begin
        st_d = ST_CTRLR;
        sh_d = {`SEA_DEV_ADDR, 1'b1};
      end
      ST_CTRLR: st_d = ST_RD_HI;
      ST_RD_HI: st_d = ST_RD_LO;
      ST_RD_LO: st_d = ST_STOP;
      ST_WR_HI: begin
        st_d = ST_WR_LO;
        sh_d = ctrl_q.data[7:0]; // R10
      end
      ST_WR_LO: st_d = ST_STOP;
      ST_STOP: st_d = (ctrl_q.al_busy && !abort_q && !last_word) ? ST_START1 : ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
    if (abort_q && st_q != ST_STOP) begin
      st_d = ST_STOP;
    end
  end

  // data line input: three flops, accepted once the last two agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      s1_q <= ee_sda_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sda_q <= s3_q;
      end
    end
  end

  // serial engine: each bit is four quarters, clock high in quarters 2 and 3
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      qcnt_q <= 13'h0000;
      sh_q <= 8'h00;
      rx_q <= 16'h0000;
      abort_q <= 1'b0;
      al_pend_q <= 1'b1;
      al_idx_q <= 7'h00;
      scl_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      sda_o_q <= 1'b0;
      cfg_q <= '0;
    end else begin
      cfg_q.valid <= 1'b0;
      if (st_q == ST_IDLE) begin
        al_pend_q <= 1'b0; // R6
        qcnt_q <= 13'h0000;
        ph_q <= 2'h0;
      end else begin
        qcnt_q <= tick ? 13'h0000 : qcnt_q + 13'h0001; // R5
      end
      if (launch) begin
        st_q <= ST_START1;
        abort_q <= 1'b0;
        al_idx_q <= 7'h00;
        bit_q <= 4'h0;
      end else if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (ph_q)
          2'h0: begin
            scl_q <= 1'b0;
            if (st_q == ST_STOP) begin
              sda_oe_n_q <= 1'b0;
            end else if (!is_byte) begin
              sda_oe_n_q <= 1'b1;
            end else if (bit_q == 4'h8) begin
              sda_oe_n_q <= !(st_q == ST_RD_HI);
            end else begin
              sda_oe_n_q <= is_rx ? 1'b1 : sh_q[7]; // R10
            end
          end
          2'h1: scl_q <= 1'b1;
          2'h2: begin
            if (st_q == ST_START1 || st_q == ST_RSTART) begin
              sda_oe_n_q <= 1'b0;
            end else if (st_q == ST_STOP) begin
              sda_oe_n_q <= 1'b1;
            end else if (is_rx && bit_q != 4'h8) begin
              rx_q <= {rx_q[14:0], sda_q}; // R11
            end
            if (ack_miss) begin
              abort_q <= 1'b1; // R3
            end
          end
          default: begin
            scl_q <= (st_q == ST_STOP);
            if (is_byte && bit_q != 4'h8) begin
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
            if (unit_done) begin
              st_q <= st_d;
              sh_q <= sh_d;
              bit_q <= 4'h0;
              if (fin && ctrl_q.al_busy) begin
                cfg_q.valid <= !abort_q;
                cfg_q.idx <= al_idx_q;
                cfg_q.data <= rx_q;
                al_idx_q <= al_idx_q + 7'h01;
              end
            end
          end
        endcase
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign ee_scl = scl_q;
  assign ee_sda_o = sda_o_q;
  assign ee_sda_oe_n = sda_oe_n_q;
  assign cfg_word = cfg_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_stop_end;
    unit_done && st_q == ST_STOP;
  endsequence
  sequence s_addr_end;
    unit_done && st_q == ST_ADDR && !abort_q;
  endsequence

  a_sw_launch: // R1
  assert property (sw_go |=> st_q == ST_START1 && ctrl_q.start && !ctrl_q.err)
    else $error("software start did not launch a cycle");
  a_start_clear: // R2
  assert property (s_stop_end ##0 !ctrl_q.al_busy |=> !ctrl_q.start && st_q == ST_IDLE)
    else $error("start bit not cleared at cycle end");
  a_ack_error: // R3
  assert property (ack_miss |=> ctrl_q.err ##1 st_q != ST_IDLE)
    else $error("missing acknowledge not flagged");
  a_al_result: // R4
  assert property ($rose(ctrl_q.al_ok) |-> $past(ctrl_q.al_busy) && !ctrl_q.al_busy)
    else $error("autoload ok without autoload end");
  a_div_slow: // R5
  assert property (!ctrl_q.al_busy && ctrl_q.clk_div == 2'b11 |-> qdiv == (DIV3 >> 2))
    else $error("wrong divisor for selection 11");
  a_al_skip: // R6
  assert property (al_pend_q && ctrl_q.al_dis && st_q == ST_IDLE |=> !ctrl_q.al_busy [*2])
    else $error("autoload ran while disabled");
  a_al_fast: // R7
  assert property (ctrl_q.al_busy && ctrl_q.fast |-> qdiv == (base >> 5))
    else $error("fast autoload divisor wrong");
  a_al_busy: // R8
  assert property (ctrl_q.al_busy |-> st_q != ST_IDLE)
    else $error("autoload busy while engine idle");
  a_addr_load: // R9
  assert property (unit_done && st_q == ST_CTRLW && !ctrl_q.al_busy && !abort_q
                   |=> st_q == ST_ADDR && sh_q == {$past(ctrl_q.addr), 1'b0})
    else $error("word address not loaded");
  a_wr_data: // R10
  assert property (s_addr_end ##0 !rd_mode |=> st_q == ST_WR_HI && sh_q == $past(ctrl_q.data[15:8]))
    else $error("write data high byte not loaded");
  a_rd_data: // R11
  assert property (sw_fin && rd_mode && !abort_q |=> ctrl_q.data == $past(rx_q))
    else $error("read word not returned");

endmodule
`default_nettype wire

// [rtl/sea_consts.svh]
// constants of the serial eeprom autoload/access block: offsets, fields, resets, divisors
// assumes inclusion by bare name from the package and the top module
`ifndef SEA_CONSTS_SVH
`define SEA_CONSTS_SVH
`define SEA_OFF_ISTAT 32'h0000_0000
`define SEA_OFF_IMASK 32'h0000_0004
`define SEA_OFF_CTRL 32'h0000_0070
`define SEA_CTRL_RST 32'h0000_0080
`define SEA_CTRL_RW_MASK 32'hffff_fef2
`define SEA_CTRL_START_BIT 0
`define SEA_CTRL_WR_BIT 1
`define SEA_DIV0 13'h1000
`define SEA_DIV1 13'h0800
`define SEA_DIV2 13'h0400
`define SEA_DIV3 13'h0080
`define SEA_FAST_SHIFT 3
`define SEA_DEV_ADDR 7'h50
`define SEA_AL_WORDS 8
`define SEA_IRQ_CYC 0
`define SEA_IRQ_ERR 1
`define SEA_IRQ_AL 2
`define SEA_IRQ_W 3
`define SEA_RESP_OKAY 2'h0
`define SEA_RESP_SLVERR 2'h2
`endif

// [rtl/sea_pkg.sv]
// types of the serial eeprom autoload/access block
// assumes sea_consts.svh on the include path
`include "sea_consts.svh"
package sea_pkg;
  typedef struct packed {
    logic [15:0] data;
    logic [6:0] addr;
    logic al_busy;
    logic fast;
    logic al_dis;
    logic [1:0] clk_div;
    logic al_ok;
    logic err;
    logic wr;
    logic start;
  } sea_ctrl_t;
  typedef struct packed {
    logic valid;
    logic [6:0] idx;
    logic [15:0] data;
  } sea_cfg_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START1, ST_CTRLW, ST_ADDR, ST_RSTART, ST_CTRLR,
    ST_RD_HI, ST_RD_LO, ST_WR_HI, ST_WR_LO, ST_STOP
  } sea_state_t;
endpackage

// [dv/sea_ee_model.sv]
// behavioural two-wire eeprom: byte address pointer, writes and sequential reads
// assumes the bench resolves the data line with a pull-up from both drivers
`timescale 1ns/1ps
`default_nettype none
module sea_ee_model (
  input wire logic scl,
  input wire logic sda,
  output logic sda_low,
  input wire logic no_ack
);
  logic [7:0] mem [256];
  logic [7:0] sh = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic rdn = 1'b0;
  int n = 0;
  int st = 0;
  initial begin
    sda_low = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // own data changes only while scl is low, so these never see a false frame edge
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    n = 0;
    st = 0;
    rd = 1'b0;
    rdn = 1'b0;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act) begin
    sh = {sh[6:0], sda};
    n = n + 1;
  end
  always @(negedge scl) if (act) begin
    if (n == 8) begin
      if (rd) begin
        sda_low = 1'b0;
        ptr = ptr + 8'h01;
      end else begin
        if (st == 0) rdn = sh[0];
        else if (st == 1) ptr = sh;
        else begin
          mem[ptr] = sh;
          ptr = ptr + 8'h01;
        end
        st = st + 1;
        // a refused acknowledge leaves the line to the pull-up
        sda_low = !no_ack;
      end
    end else if (n == 9) begin
      n = 0;
      sda_low = 1'b0;
      if (rd && sh[0]) begin
        rd = 1'b0;
        rdn = 1'b0;
      end else rd = rdn;
    end
    if (rd && n < 8) sda_low = !mem[ptr][7 - n];
  end
endmodule
`default_nettype wire

// [dv/serial_eeprom_autoload_access_bench.sv]
// self-checking bench of the serial eeprom autoload/access block
// assumes sea_ee_model on the eeprom pins and a pull-up on the data line
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_autoload_access_bench import sea_pkg::*; ;
  typedef struct packed {logic w; logic [6:0] a; logic [15:0] d; logic [1:0] v; logic [15:0] e;} sea_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic no_ack = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [3:0] ws = 4'hf;
  logic [2:0] prot = 3'h0;
  logic [31:0] wd = 32'h0000_0000, rd;
  logic [1:0] br, rr;
  logic awr, wrdy, bv, arr, rv, scl, sda_o, oe_n, ee_low, irq;
  wire logic sda;
  sea_cfg_t cfg;
  int fails = 0, comparisons = 0, cyc = 0, al_n = 0;
  int dv [4] = '{128, 96, 64, 32};
  // shorter divisors than the real part keep the run brief; periods follow these
  sea_row_t rows [5] = '{'{1, 7'h05, 16'h1234, 2'h3, 16'h1234}, '{0, 7'h05, 16'h0000, 2'h2, 16'h1234},
    '{0, 7'h09, 16'h0000, 2'h1, 16'h4849}, '{1, 7'h7f, 16'hbeef, 2'h0, 16'hbeef},
    '{0, 7'h7f, 16'h0000, 2'h3, 16'hbeef}};
  assign sda = ((!oe_n && !sda_o) || ee_low) ? 1'b0 : 1'b1;
  sea_top #(.DIV0(13'h0080), .DIV1(13'h0060), .DIV2(13'h0040), .DIV3(13'h0020), .AL_WORDS(2))
  sea_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(prot),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
    .s_axi_arprot(prot), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .ee_scl(scl), .ee_sda_i(sda), .ee_sda_o(sda_o),
    .ee_sda_oe_n(oe_n), .cfg_word(cfg), .irq(irq));
  sea_ee_model sea_ee_model_inst (.scl(scl), .sda(sda), .sda_low(ee_low), .no_ack(no_ack));
  initial forever #10 aclk = ~aclk;
  function automatic logic [7:0] ev(input int i);
    return 8'(i) ^ 8'h5a;
  endfunction
  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wrdy === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = br;
    brdy <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd;
    r = rr;
    rrdy <= 1'b0;
  endtask
  // software side waits for the bit to drop before touching the fields again
  task automatic poll(input int b, output logic [31:0] d);
    logic [1:0] r;
    int k;
    k = 0;
    do begin
      axr(12'h070, d, r);
      k++;
    end while (d[b] !== 1'b0 && k < 5000);
  endtask
  // bit period measured inside the first byte, clear of the start unit
  task automatic per(input int e);
    time t;
    repeat (3) @(posedge scl);
    t = $time;
    @(posedge scl);
    chk(32'(($time - t) / 20), 32'(e));
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      stop_test;
    end
  end
  always @(posedge aclk) if (cfg.valid === 1'b1) begin
    chk({9'h0, cfg.idx, cfg.data}, {9'h0, 7'(al_n), ev(2 * al_n), ev(2 * al_n + 1)});
    al_n++;
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axr(12'h070, d, r);
    chk(d & 32'h0000_01fc, 32'h0000_0180);
    per(16);
    poll(8, d);
    chk(d, 32'h0000_0088);
    chk(32'(al_n), 32'd2);
    chk(32'(irq), 32'd0);
    axr(12'h000, d, r);
    chk(d, 32'h0000_0004);
    axw(12'h000, 32'h0000_0004, r);
    axr(12'h000, d, r);
    chk(d, 32'h0000_0000);
    $display("test autoload done");
    for (int i = 0; i < 5; i++) begin
      axw(12'h070, {rows[i].d, rows[i].a, 3'b010, rows[i].v, 2'b00, rows[i].w, 1'b1}, r);
      per(dv[rows[i].v]);
      poll(0, d);
      chk(d, {rows[i].e, rows[i].a, 3'b010, rows[i].v, 2'b10, rows[i].w, 1'b0});
      if (rows[i].w) chk({16'h0, sea_ee_model_inst.mem[{rows[i].a, 1'b0}],
        sea_ee_model_inst.mem[{rows[i].a, 1'b1}]}, {16'h0, rows[i].e});
      $display("test row %0d done", i);
    end
    no_ack <= 1'b1;
    axw(12'h004, 32'h0000_0002, r);
    axw(12'h070, {16'hcafe, 7'h03, 3'b010, 2'h3, 4'b0001}, r);
    poll(0, d);
    chk(d, {16'hcafe, 7'h03, 3'b010, 2'h3, 4'b1100});
    axr(12'h000, d, r);
    chk(d & 32'h0000_0002, 32'h0000_0002);
    chk(32'(irq), 32'd1);
    axw(12'h000, 32'h0000_0003, r);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'd0);
    $display("test missing acknowledge done");
    // only byte lane 2 may land; protection bits are ignored by the slave
    ws <= 4'h4;
    prot <= 3'h2;
    axw(12'h070, 32'hffff_ffff, r);
    ws <= 4'hf;
    prot <= 3'h0;
    axr(12'h070, d, r);
    chk(d, 32'hcaff_06bc);
    $display("test byte strobe done");
    axw(12'h010, 32'hffff_ffff, r);
    chk_r(r, 2'h2);
    axr(12'h010, d, r);
    chk_r(r, 2'h2);
    chk(d, 32'h0000_0000);
    $display("test unmapped done");
    stop_test;
  end
endmodule
`default_nettype wire
